// [rtl/tso_gate_if.sv]
// control and result signals between register logic and phase shaper
`timescale 1ns/10ps
interface tso_gate_if;
    logic       pos_level;
    logic       rev_level;
    logic       toggle_en;
    logic       gate_func;
    logic       pos_chop;
    logic       rev_chop;
    logic       fb_sel;
    logic [2:0] phase_sw;
    logic       pwm_mode;
    logic       running;
    logic [5:0] pin_level;
    logic       toggle;

    modport ctl (
        output pos_level, rev_level, toggle_en, gate_func, pos_chop, rev_chop,
        output fb_sel, phase_sw, pwm_mode, running,
        input  pin_level, toggle
    );
    modport phase (
        input  pos_level, rev_level, toggle_en, gate_func, pos_chop, rev_chop,
        input  fb_sel, phase_sw, pwm_mode, running,
        output pin_level, toggle
    );
endinterface

// [rtl/tso_phase_out.sv]
// complementary pwm phase shaping and motor gate pattern
`timescale 1ns/10ps
module tso_phase_out (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  wire logic   standby,
    tso_gate_if.phase   gi,
    input  wire logic [2:0] up_match,
    input  wire logic [2:0] dn_match,
    input  wire logic   dead_time_done,
    input  wire logic   period_evt,
    input  wire logic [2:0] hall_in
);
    logic [2:0]        pos_act_r;
    logic [2:0]        pos_act_nxt;
    tso_pkg::tso_dead_e dead_r;
    tso_pkg::tso_dead_e dead_nxt;
    logic              toggle_r;
    logic              toggle_nxt;
    logic [2:0]        rev_act;
    logic [5:0]        gate;
    logic [2:0]        fb;

    // active flag to pin level: level bit 0 means active low
    function automatic logic lvl(input logic act, input logic sel);
        return act ? sel : ~sel;
    endfunction

    // ************************************************************
    // phase state
    // ************************************************************
    always_comb begin
        pos_act_nxt = pos_act_r;
        dead_nxt    = dead_r;
        toggle_nxt  = toggle_r;
        if (!gi.running) begin
            pos_act_nxt = 3'h0;
            dead_nxt    = tso_pkg::TSO_IDLE;
        end else begin
            pos_act_nxt = (pos_act_r | up_match) & ~dn_match;
            unique case (dead_r)
                tso_pkg::TSO_IDLE: dead_nxt = tso_pkg::TSO_DEAD;
                tso_pkg::TSO_DEAD: dead_nxt = dead_time_done ? tso_pkg::TSO_RUN
                                                             : tso_pkg::TSO_DEAD;
                tso_pkg::TSO_RUN:  dead_nxt = tso_pkg::TSO_RUN;
                default:           dead_nxt = tso_pkg::TSO_IDLE;
            endcase
        end
        if (gi.toggle_en && period_evt) begin
            toggle_nxt = ~toggle_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || standby) begin
            pos_act_r <= 3'h0;
            dead_r    <= tso_pkg::TSO_IDLE;
            toggle_r  <= 1'b0;
        end else begin
            pos_act_r <= pos_act_nxt;
            dead_r    <= dead_nxt;
            toggle_r  <= toggle_nxt;
        end
    end

    // ************************************************************
    // gate pattern and pin levels
    // ************************************************************
    always_comb begin
        // feedback from register bits or hall inputs
        fb = gi.fb_sel ? gi.phase_sw : hall_in;
        // order: w_rev v_rev u_rev w_pos v_pos u_pos
        unique case (fb)
            3'h1:    gate = 6'h21;
            3'h2:    gate = 6'h0a;
            3'h3:    gate = 6'h22;
            3'h4:    gate = 6'h14;
            3'h5:    gate = 6'h11;
            3'h6:    gate = 6'h0c;
            default: gate = 6'h00;
        endcase
        // reverse phase opposite sense, held idle until dead time
        rev_act = (dead_r == tso_pkg::TSO_RUN) ? ~pos_act_r : 3'h0;
        for (int i = 0; i < 3; i++) begin
            // gate function replaces ordinary pwm output
            if (gi.gate_func) begin
                gi.pin_level[i]   = lvl(gate[i] & (pos_act_r[i] | ~gi.pos_chop),
                                        gi.pos_level);
                gi.pin_level[i+3] = lvl(gate[i+3] & (rev_act[i] | ~gi.rev_chop),
                                        gi.rev_level);
            end else begin
                gi.pin_level[i]   = lvl(pos_act_r[i], gi.pos_level);
                gi.pin_level[i+3] = lvl(rev_act[i], gi.rev_level);
            end
        end
    end

    assign gi.toggle = toggle_r;

    // reverse held inactive before dead time while gate function is clear
    a_rev_dead_hold: assert property (@(posedge sys_clk) disable iff (rst || standby)
        (dead_r != tso_pkg::TSO_RUN && !gi.gate_func)
            |-> (gi.pin_level[5:3] == {3{~gi.rev_level}}))
        else $error("reverse phase active before dead time");

    a_toggle_off: assert property (@(posedge sys_clk) disable iff (rst || standby)
        (!gi.toggle_en && !rst && !standby) |=> $stable(toggle_r))
        else $error("toggle moved while disabled");
endmodule

// [rtl/tso_pkg.sv]
// constants and types shared by the timer sync and output control block
package tso_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NCH    = 5;
    localparam int CNT_W  = 16;
    localparam int NPIN   = 6;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFF_SYNC = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_OE   = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_LVL  = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_GATE = 4'h3;

    // ************************************************************
    // writable masks, fixed read bits, reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] SYNC_WMASK = 8'hc7;
    localparam logic [DATA_W-1:0] SYNC_FIXED = 8'h00;
    localparam logic [DATA_W-1:0] SYNC_RST   = 8'h00;
    localparam logic [DATA_W-1:0] OE_WMASK   = 8'h3f;
    localparam logic [DATA_W-1:0] OE_FIXED   = 8'hc0;
    localparam logic [DATA_W-1:0] OE_RST     = 8'hc0;
    localparam logic [DATA_W-1:0] LVL_WMASK  = 8'h43;
    localparam logic [DATA_W-1:0] LVL_FIXED  = 8'hbc;
    localparam logic [DATA_W-1:0] LVL_RST    = 8'h00;
    localparam logic [DATA_W-1:0] GATE_WMASK = 8'h7f;
    localparam logic [DATA_W-1:0] GATE_FIXED = 8'h80;
    localparam logic [DATA_W-1:0] GATE_RST   = 8'h80;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SYNC_CH4_BIT   = 7;
    localparam int SYNC_CH3_BIT   = 6;
    localparam int LVL_TOGGLE_BIT = 6;
    localparam int LVL_REV_BIT    = 1;
    localparam int LVL_POS_BIT    = 0;
    localparam int GATE_FUNC_BIT  = 6;
    localparam int GATE_REVCH_BIT = 5;
    localparam int GATE_POSCH_BIT = 4;
    localparam int GATE_FBSEL_BIT = 3;
    localparam int SYNC_MIN_CH    = 2;

    // reverse-phase start-up state
    typedef enum logic [1:0] {
        TSO_IDLE,
        TSO_DEAD,
        TSO_RUN
    } tso_dead_e;
endpackage

// [rtl/tso_top.sv]
// timer channel sync, output enable, level and motor gate control
//
// Summary of operation
// - five sync bits: ch4 b7, ch3 b6, ch2-0
// - presets and clears spread across synced channels
// - sync clear also needs clear source selected
// - unsynced channels run fully independent
// - sync register zero on reset, standby
// - sync bits 5-3 read zero
// - pin drives only while its enable set
// - enable register resets c0, top bits one
// - level bit 6 enables period toggle
// - level bit 1 selects reverse phase polarity
// - reverse phase goes active after dead time, except gate function with reverse chop clear
// - level bit 0 selects positive phase polarity
// - gate register resets 80, bit 7 one
// - gate settings only in pwm modes
// - gate bits: function, chop, feedback, switches
// - gate function bit picks gate output
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
module tso_top #(
    parameter int NCH   = tso_pkg::NCH,
    parameter int CNT_W = tso_pkg::CNT_W
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       standby,
    input  wire logic [tso_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tso_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [tso_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [NCH-1:0]             preset_req,
    input  wire logic [CNT_W-1:0]           preset_val,
    input  wire logic [NCH-1:0]             clear_req,
    input  wire logic [NCH-1:0]             clear_src_sync,
    output logic      [NCH-1:0]             counter_load,
    output logic      [CNT_W-1:0]           counter_load_val,
    output logic      [NCH-1:0]             counter_clear,
    output logic                            sync_active,
    input  wire logic                       pwm_mode,
    input  wire logic                       counter_running,
    input  wire logic                       dead_time_done,
    input  wire logic [2:0]                 up_match,
    input  wire logic [2:0]                 dn_match,
    input  wire logic                       period_evt,
    input  wire logic [2:0]                 hall_in,
    input  wire logic [5:0]                 ordinary_out,
    output logic      [5:0]                 pin_out,
    output logic      [5:0]                 pin_oe,
    output logic                            period_toggle_out
);
    localparam int DW = tso_pkg::DATA_W;

    logic [DW-1:0]    channel_sync_select_r;
    logic [DW-1:0]    channel_sync_select_nxt;
    logic [DW-1:0]    output_master_enable_r;
    logic [DW-1:0]    output_master_enable_nxt;
    logic [DW-1:0]    output_level_control_r;
    logic [DW-1:0]    output_level_control_nxt;
    logic [DW-1:0]    motor_gate_control_r;
    logic [DW-1:0]    motor_gate_control_nxt;
    logic [DW-1:0]    rdata_r;
    logic [DW-1:0]    rdata_nxt;
    logic [NCH-1:0]   sync_vec;
    logic [NCH-1:0]   load_r;
    logic [NCH-1:0]   load_nxt;
    logic [CNT_W-1:0] load_val_r;
    logic [CNT_W-1:0] load_val_nxt;
    logic [NCH-1:0]   clear_r;
    logic [NCH-1:0]   clear_nxt;
    logic             sync_ok;
    logic [5:0]       pin_r;
    logic [5:0]       pin_nxt;
    logic [5:0]       oe_r;
    logic [5:0]       oe_nxt;

    tso_gate_if gi ();

    // merge a write into the writable bits, fixed bits forced
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] cur,
                                            input logic [DW-1:0] wd,
                                            input logic [DW-1:0] wmask,
                                            input logic [DW-1:0] fixed);
        return (wd & wmask) | (cur & ~wmask & ~fixed) | fixed;
    endfunction

    function automatic int count_ones(input logic [NCH-1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < NCH; i++) begin
            n = n + int'(v[i]);
        end
        return n;
    endfunction

    // ************************************************************
    // register file
    // ************************************************************
    always_comb begin
        channel_sync_select_nxt  = channel_sync_select_r;
        output_master_enable_nxt = output_master_enable_r;
        output_level_control_nxt = output_level_control_r;
        motor_gate_control_nxt   = motor_gate_control_r;
        rdata_nxt                = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                tso_pkg::OFF_SYNC: channel_sync_select_nxt = merge(channel_sync_select_r,
                                       reg_wdata, tso_pkg::SYNC_WMASK, tso_pkg::SYNC_FIXED);
                tso_pkg::OFF_OE:   output_master_enable_nxt = merge(output_master_enable_r,
                                       reg_wdata, tso_pkg::OE_WMASK, tso_pkg::OE_FIXED);
                tso_pkg::OFF_LVL:  output_level_control_nxt = merge(output_level_control_r,
                                       reg_wdata, tso_pkg::LVL_WMASK, '0);
                tso_pkg::OFF_GATE: motor_gate_control_nxt = merge(motor_gate_control_r,
                                       reg_wdata, tso_pkg::GATE_WMASK, tso_pkg::GATE_FIXED);
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                tso_pkg::OFF_SYNC: rdata_nxt = channel_sync_select_r;
                tso_pkg::OFF_OE:   rdata_nxt = output_master_enable_r;
                tso_pkg::OFF_LVL:  rdata_nxt = output_level_control_r | tso_pkg::LVL_FIXED;
                tso_pkg::OFF_GATE: rdata_nxt = motor_gate_control_r;
                default:           rdata_nxt = '0;
            endcase
        end
    end

    // manual reset is deliberately not a port: it must not touch these registers
    always_ff @(posedge sys_clk) begin
        if (rst || standby) begin
            channel_sync_select_r  <= tso_pkg::SYNC_RST;
            output_master_enable_r <= tso_pkg::OE_RST;
            output_level_control_r <= tso_pkg::LVL_RST;
            motor_gate_control_r   <= tso_pkg::GATE_RST;
            rdata_r                <= '0;
        end else begin
            channel_sync_select_r  <= channel_sync_select_nxt;
            output_master_enable_r <= output_master_enable_nxt;
            output_level_control_r <= output_level_control_nxt;
            motor_gate_control_r   <= motor_gate_control_nxt;
            rdata_r                <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ************************************************************
    // channel synchronisation
    // ************************************************************
    // bit-to-channel mapping
    assign sync_vec = {channel_sync_select_r[tso_pkg::SYNC_CH4_BIT],
                       channel_sync_select_r[tso_pkg::SYNC_CH3_BIT],
                       channel_sync_select_r[2:0]};

    always_comb begin
        // a lone marked channel has nobody to follow, so it behaves independently
        sync_ok      = count_ones(sync_vec) >= tso_pkg::SYNC_MIN_CH;
        load_val_nxt = load_val_r;
        load_nxt     = preset_req;
        clear_nxt    = clear_req;
        if (|preset_req) begin
            load_val_nxt = preset_val;
        end
        if (sync_ok) begin
            // preset to one synced channel loads all
            if (|(preset_req & sync_vec)) begin
                load_nxt = load_nxt | sync_vec;
            end
            // follow a clear only with clear source set
            if (|(clear_req & sync_vec)) begin
                clear_nxt = clear_nxt | (sync_vec & clear_src_sync);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || standby) begin
            load_r     <= '0;
            load_val_r <= '0;
            clear_r    <= '0;
        end else begin
            load_r     <= load_nxt;
            load_val_r <= load_val_nxt;
            clear_r    <= clear_nxt;
        end
    end

    assign counter_load     = load_r;
    assign counter_load_val = load_val_r;
    assign counter_clear    = clear_r;
    assign sync_active      = sync_ok;

    // ************************************************************
    // phase shaper and pin drive
    // ************************************************************
    assign gi.pos_level = output_level_control_r[tso_pkg::LVL_POS_BIT];
    assign gi.rev_level = output_level_control_r[tso_pkg::LVL_REV_BIT];
    assign gi.toggle_en = output_level_control_r[tso_pkg::LVL_TOGGLE_BIT];
    // gate control only inside pwm modes
    assign gi.gate_func = pwm_mode && motor_gate_control_r[tso_pkg::GATE_FUNC_BIT];
    assign gi.rev_chop  = motor_gate_control_r[tso_pkg::GATE_REVCH_BIT];
    assign gi.pos_chop  = motor_gate_control_r[tso_pkg::GATE_POSCH_BIT];
    assign gi.fb_sel    = motor_gate_control_r[tso_pkg::GATE_FBSEL_BIT];
    assign gi.phase_sw  = motor_gate_control_r[2:0];
    assign gi.pwm_mode  = pwm_mode;
    assign gi.running   = counter_running;

    tso_phase_out u_phase (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .standby        (standby),
        .gi             (gi.phase),
        .up_match       (up_match),
        .dn_match       (dn_match),
        .dead_time_done (dead_time_done),
        .period_evt     (period_evt),
        .hall_in        (hall_in)
    );

    always_comb begin
        // pin order: w_rev v_rev u_rev w_pos v_pos u_pos
        pin_nxt = pwm_mode ? gi.pin_level : ordinary_out;
        oe_nxt  = output_master_enable_r[5:0];
    end

    always_ff @(posedge sys_clk) begin
        if (rst || standby) begin
            pin_r <= '0;
            oe_r  <= '0;
        end else begin
            pin_r <= pin_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign pin_out           = pin_r;
    assign pin_oe            = oe_r;
    assign period_toggle_out = gi.toggle;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || standby);

    a_sync_preset_fan: assert property (
        (sync_ok && |(preset_req & sync_vec) && !reg_wr) |=> ((counter_load & sync_vec)
            == $past(sync_vec)))
        else $error("synced preset did not reach all synced channels");

    a_indep_preset: assert property (
        (!sync_vec[0] && !preset_req[0]) |=> !counter_load[0])
        else $error("independent channel loaded by another");

    a_clear_needs_src: assert property (
        (!clear_req[1] && !clear_src_sync[1]) |=> !counter_clear[1])
        else $error("sync clear without clear source");

    a_sync_clear_fan: assert property (
        (sync_ok && sync_vec[2] && clear_src_sync[2] && |(clear_req & sync_vec))
            |=> counter_clear[2])
        else $error("synced clear not propagated");

    a_oe_follows_en: assert property (
        reg_wr && reg_addr == tso_pkg::OFF_OE |=> ##1 (pin_oe == $past(reg_wdata[5:0], 2)))
        else $error("pin enable not following register");

    a_oe_fixed_ones: assert property (
        output_master_enable_r[7:6] == 2'h3)
        else $error("enable register top bits not one");

    a_sync_resv_zero: assert property (
        reg_rd && reg_addr == tso_pkg::OFF_SYNC |=> reg_rdata[5:3] == 3'h0)
        else $error("sync reserved bits read nonzero");

    a_gate_fixed_one: assert property (
        reg_rd && reg_addr == tso_pkg::OFF_GATE |=> reg_rdata[7])
        else $error("gate bit 7 not one");

    a_gate_ignored: assert property (
        !pwm_mode |=> pin_out == $past(ordinary_out))
        else $error("pins not ordinary outside pwm mode");

    a_reset_values: assert property (@(posedge sys_clk) disable iff (1'b0)
        rst |=> (channel_sync_select_r == tso_pkg::SYNC_RST
                 && motor_gate_control_r == tso_pkg::GATE_RST
                 && output_level_control_r == tso_pkg::LVL_RST))
        else $error("registers not at reset value");
endmodule

// [test/tso_stage_model.sv]
// motor power stage gate drivers as seen from the six drive pins
`timescale 1ns/10ps
module tso_stage_model (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [2:0] hall_set,
    output logic      [5:0] gate_seen,
    output logic      [2:0] hall_in
);
    // released pins
    // stage inputs carry pull-downs, so a pin not driven reads low
    assign gate_seen = pin_oe & pin_out;
    assign hall_in   = hall_set;
endmodule

// [test/tso_top_tb_top.sv]
// self-checking bench for the timer sync and output control block
`timescale 1ns/10ps
module tso_top_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        standby = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [4:0]  preset_req = 5'h00, clear_req = 5'h00, clear_src_sync = 5'h00;
    logic [15:0] preset_val = 16'h0000;
    logic [4:0]  counter_load, counter_clear;
    logic [15:0] counter_load_val;
    logic        sync_active, period_toggle_out;
    logic        pwm_mode = 1'b0, counter_running = 1'b0;
    logic        dead_time_done = 1'b0, period_evt = 1'b0;
    logic [2:0]  up_match = 3'h0, dn_match = 3'h0, hall_in, hall_set = 3'h2;
    logic [5:0]  ordinary_out = 6'h2a, pin_out, pin_oe, gate_seen;
    int          fails = 0;
    int          tests_run = 0;

    always #25 sys_clk = ~sys_clk;

    tso_top i_tso_top (
        .sys_clk(sys_clk), .rst(rst), .standby(standby), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .preset_req(preset_req), .preset_val(preset_val), .clear_req(clear_req),
        .clear_src_sync(clear_src_sync), .counter_load(counter_load),
        .counter_load_val(counter_load_val), .counter_clear(counter_clear),
        .sync_active(sync_active), .pwm_mode(pwm_mode), .counter_running(counter_running),
        .dead_time_done(dead_time_done), .up_match(up_match), .dn_match(dn_match),
        .period_evt(period_evt), .hall_in(hall_in), .ordinary_out(ordinary_out),
        .pin_out(pin_out), .pin_oe(pin_oe), .period_toggle_out(period_toggle_out)
    );
    tso_stage_model i_tso_stage_model (
        .pin_out(pin_out), .pin_oe(pin_oe), .hall_set(hall_set),
        .gate_seen(gate_seen), .hall_in(hall_in)
    );

    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic test_done();
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    task automatic sreq(input logic [4:0] p, input logic [4:0] c, input logic [15:0] v);
        @(posedge sys_clk);
        preset_req <= p;
        clear_req <= c;
        preset_val <= v;
        @(posedge sys_clk);
        preset_req <= 5'h00;
        clear_req <= 5'h00;
        #1;
    endtask
    // shaper inputs are levels or one-cycle pulses; four cycles cover the latency
    task automatic pins(input logic [5:0] e, input logic [2:0] up, input logic [2:0] dn);
        @(posedge sys_clk);
        up_match <= up;
        dn_match <= dn;
        @(posedge sys_clk);
        up_match <= 3'h0;
        dn_match <= 3'h0;
        repeat (3) @(posedge sys_clk);
        #1 chk("pin_out", {10'h000, e}, {10'h000, pin_out});
    endtask

    initial begin
        #(50 * 4000);
        fails++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(tso_pkg::OFF_SYNC, 8'h00);
        rd(tso_pkg::OFF_OE, 8'hc0);
        rd(tso_pkg::OFF_LVL, 8'hbc);
        rd(tso_pkg::OFF_GATE, 8'h80);
        rd(4'h9, 8'h00);
        wr(tso_pkg::OFF_SYNC, 8'hff);
        rd(tso_pkg::OFF_SYNC, 8'hc7);
        wr(tso_pkg::OFF_OE, 8'h00);
        rd(tso_pkg::OFF_OE, 8'hc0);
        wr(tso_pkg::OFF_LVL, 8'h00);
        rd(tso_pkg::OFF_LVL, 8'hbc);
        wr(tso_pkg::OFF_GATE, 8'h00);
        rd(tso_pkg::OFF_GATE, 8'h80);
        wr(tso_pkg::OFF_SYNC, 8'hc1);
        sreq(5'h10, 5'h00, 16'h1234);
        chk("counter_load", 16'h0019, {11'h000, counter_load});
        chk("counter_load_val", 16'h1234, counter_load_val);
        sreq(5'h04, 5'h00, 16'h00a5);
        chk("counter_load", 16'h0004, {11'h000, counter_load});
        wr(tso_pkg::OFF_SYNC, 8'h07);
        clear_src_sync <= 5'h05;
        sreq(5'h00, 5'h01, 16'h0000);
        chk("counter_clear", 16'h0005, {11'h000, counter_clear});
        chk("sync_active", 16'h0001, {15'h0000, sync_active});
        wr(tso_pkg::OFF_SYNC, 8'h01);
        sreq(5'h01, 5'h08, 16'h0042);
        chk("counter_load", 16'h0001, {11'h000, counter_load});
        chk("counter_clear", 16'h0008, {11'h000, counter_clear});
        chk("sync_active", 16'h0000, {15'h0000, sync_active});
        chk("gate_seen", 16'h0000, {10'h000, gate_seen});
        wr(tso_pkg::OFF_OE, 8'h3f);
        wr(tso_pkg::OFF_GATE, 8'h4f);
        pins(6'h2a, 3'h0, 3'h0);
        chk("pin_oe", 16'h003f, {10'h000, pin_oe});
        chk("gate_seen", 16'h002a, {10'h000, gate_seen});
        wr(tso_pkg::OFF_GATE, 8'h00);
        pwm_mode <= 1'b1;
        pins(6'h3f, 3'h0, 3'h0);
        @(posedge sys_clk);
        counter_running <= 1'b1;
        pins(6'h3e, 3'h1, 3'h0);
        @(posedge sys_clk);
        dead_time_done <= 1'b1;
        pins(6'h0e, 3'h0, 3'h0);
        wr(tso_pkg::OFF_LVL, 8'h03);
        pins(6'h31, 3'h0, 3'h0);
        pins(6'h38, 3'h0, 3'h1);
        wr(tso_pkg::OFF_GATE, 8'h49);
        pins(6'h21, 3'h0, 3'h0);
        wr(tso_pkg::OFF_GATE, 8'h47);
        pins(6'h0a, 3'h0, 3'h0);
        wr(tso_pkg::OFF_LVL, 8'h43);
        pulse_period();
        chk("period_toggle_out", 16'h0001, {15'h0000, period_toggle_out});
        wr(tso_pkg::OFF_LVL, 8'h03);
        pulse_period();
        chk("period_toggle_out", 16'h0001, {15'h0000, period_toggle_out});
        @(posedge sys_clk);
        standby <= 1'b1;
        @(posedge sys_clk);
        standby <= 1'b0;
        rd(tso_pkg::OFF_SYNC, 8'h00);
        rd(tso_pkg::OFF_OE, 8'hc0);
        chk("pin_oe", 16'h0000, {10'h000, pin_oe});
        test_done();
    end

    task automatic pulse_period();
        @(posedge sys_clk);
        period_evt <= 1'b1;
        @(posedge sys_clk);
        period_evt <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
endmodule
